/* File: ldc_cfg.svh */
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH

// control byte layout
`define LDC_TYPE_BIT    7
`define LDC_BIAS_BIT    6
`define LDC_EN_BIT      0
`define LDC_CTRL_RST    8'h00

// panel geometry
`define LDC_NUM_COM     4
`define LDC_NUM_SEG     8
`define LDC_ADDR_W      3
`define LDC_PHASE_W     2
`define LDC_LAST_PHASE  2'h3

// lcd clock ticks per time division, and where type A inverts
`define LDC_DIV_TICKS   4
`define LDC_HALF_TICKS  2
`define LDC_CNT_W       2
`define LDC_LAST_TICK   2'h3
`define LDC_HALF_CNT    2'h2

`endif

/* File: ldc_pkg.sv */
package ldc_pkg;

    typedef enum logic [1:0]
    {
        LDC_LVL_VSS = 2'h0,
        LDC_LVL_VC  = 2'h1,
        LDC_LVL_VB  = 2'h2,
        LDC_LVL_VA  = 2'h3
    } ldc_level_e;

    typedef enum logic
    {
        LDC_WAVE_A = 1'h0,
        LDC_WAVE_B = 1'h1
    } ldc_wave_e;

    typedef enum logic
    {
        LDC_BIAS_R = 1'h0,
        LDC_BIAS_C = 1'h1
    } ldc_bias_e;

    typedef enum logic
    {
        LDC_SEQ_HOLD = 1'h0,
        LDC_SEQ_RUN  = 1'h1
    } ldc_seq_e;

endpackage

/* File: ldc_line_drv.sv */
`timescale 1ns/1ns
// one panel line: level from selection and polarity, 1/3 bias
module ldc_line_drv
(
    input  wire logic               active,
    input  wire logic               is_com,
    input  wire logic               positive,
    output ldc_pkg::ldc_level_e     level
);
    logic [1:0] pos_code;

    always_comb
    begin
        if (is_com)
            pos_code = active ? 2'h3 : 2'h1;
        else
            pos_code = active ? 2'h0 : 2'h2;
        // negative half mirrors the levels so the pixel sees no dc
        level = ldc_pkg::ldc_level_e'(positive ? pos_code : ~pos_code);
    end
endmodule // ldc_line_drv

/* File: ldc_phase_seq.sv */
`timescale 1ns/1ns
`include "ldc_cfg.svh"
// time divisions, common phase and drive polarity
module ldc_phase_seq
(
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     hold,
    input  wire logic                     wave_b,
    input  wire logic                     tick,
    output logic                          run,
    output logic [`LDC_PHASE_W-1:0]       phase,
    output logic                          positive
);
    ldc_pkg::ldc_seq_e          st_q, st_d;
    logic [`LDC_CNT_W-1:0]      cnt_q, cnt_d;
    logic [`LDC_PHASE_W-1:0]    phase_q, phase_d;
    logic                       frame_q, frame_d;

    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        phase_d = phase_q;
        frame_d = frame_q;
        case (st_q)
            ldc_pkg::LDC_SEQ_HOLD:
            begin
                if (!hold)
                    st_d = ldc_pkg::LDC_SEQ_RUN;
            end
            ldc_pkg::LDC_SEQ_RUN:
            begin
                if (tick)
                begin
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q == `LDC_LAST_TICK)
                    begin
                        phase_d = phase_q + 2'h1;
                        if (phase_q == `LDC_LAST_PHASE)
                            frame_d = ~frame_q;
                    end
                end
            end
            default:
                st_d = ldc_pkg::LDC_SEQ_HOLD;
        endcase
        if (hold)
        begin
            // restart at the first phase after lcd reset
            st_d    = ldc_pkg::LDC_SEQ_HOLD;
            cnt_d   = '0;
            phase_d = '0;
            frame_d = 1'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q    <= ldc_pkg::LDC_SEQ_HOLD;
            cnt_q   <= '0;
            phase_q <= '0;
            frame_q <= 1'h0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            frame_q <= frame_d;
        end
    end

    assign run   = (st_q == ldc_pkg::LDC_SEQ_RUN);
    assign phase = phase_q;
    // type a flips mid division, type b once per frame
    assign positive = wave_b ? ~frame_q : (cnt_q < `LDC_HALF_CNT);
endmodule // ldc_phase_seq

/* File: ldc_display_ctrl.sv */
`timescale 1ns/1ns
`include "ldc_cfg.svh"
// What this block does
// - lcd reset is not-enabled or sleep
// - entering sleep resets lcd regardless of enable
// - clearing enable bit resets lcd
// - reset drives lines low, else normal
// - four commons, four divisions per frame
// - waveform scheme A or B selectable
// - scheme B gives lower drive frequency
// - bias kind resistor or capacitor selectable
// - zero net dc on every pixel
// - enable zero stops all driving signals
// - enable bit clear after power-on
// - segment state taken from display memory bit
// - control bit 7 selects waveform scheme
// - control bit 6 selects bias kind
// - control bit 0 is display enable
module ldc_display_ctrl
(
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic [7:0]                   display_ctrl_first,
    input  wire logic                         sleep_mode,
    input  wire logic                         lcd_tick,
    input  wire logic                         mem_wr_en,
    input  wire logic [`LDC_ADDR_W-1:0]       mem_wr_addr,
    input  wire logic [`LDC_NUM_COM-1:0]      mem_wr_data,
    output logic [2*`LDC_NUM_COM-1:0]         com_level_q,
    output logic [2*`LDC_NUM_SEG-1:0]         seg_level_q,
    output logic                              bias_kind_q,
    output logic                              drive_on_q
);
    logic                       display_on_ctl_q, display_on_ctl_d;
    logic                       sleep_q, sleep_d;
    logic                       wave_q, wave_d;
    logic                       bias_kind_d;
    logic                       lcd_rst;
    logic                       run;
    logic                       positive;
    logic [`LDC_PHASE_W-1:0]    phase;
    logic [`LDC_NUM_COM-1:0]    mem_q [`LDC_NUM_SEG];
    logic [`LDC_NUM_COM-1:0]    mem_d [`LDC_NUM_SEG];
    logic [2*`LDC_NUM_COM-1:0]  com_level_d;
    logic [2*`LDC_NUM_SEG-1:0]  seg_level_d;
    logic                       drive_on_d;

    // control byte capture; enable clears at power-on
    always_comb
    begin
        display_on_ctl_d = display_ctrl_first[`LDC_EN_BIT];
        wave_d           = display_ctrl_first[`LDC_TYPE_BIT];
        bias_kind_d      = display_ctrl_first[`LDC_BIAS_BIT];
        sleep_d          = sleep_mode;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            display_on_ctl_q <= 1'(`LDC_CTRL_RST >> `LDC_EN_BIT);
            wave_q           <= 1'(`LDC_CTRL_RST >> `LDC_TYPE_BIT);
            bias_kind_q      <= 1'(`LDC_CTRL_RST >> `LDC_BIAS_BIT);
            sleep_q          <= 1'h0;
        end
        else
        begin
            display_on_ctl_q <= display_on_ctl_d;
            wave_q           <= wave_d;
            bias_kind_q      <= bias_kind_d;
            sleep_q          <= sleep_d;
        end
    end

    // sleep wins over enable; clearing enable also resets
    assign lcd_rst = ~display_on_ctl_q | sleep_q;

    ldc_phase_seq u_seq
    (
        .clk      (clk),
        .reset_n  (reset_n),
        .hold     (lcd_rst),
        .wave_b   (wave_q == ldc_pkg::LDC_WAVE_B),
        .tick     (lcd_tick),
        .run      (run),
        .phase    (phase),
        .positive (positive)
    );

    // display memory: one row per segment, one bit per common
    genvar g;
    generate
        for (g = 0; g < `LDC_NUM_SEG; g++)
        begin : g_mem
            always_comb
            begin
                mem_d[g] = mem_q[g];
                if (mem_wr_en && (mem_wr_addr == `LDC_ADDR_W'(g)))
                    mem_d[g] = mem_wr_data;
            end

            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    mem_q[g] <= '0;
                else
                    mem_q[g] <= mem_d[g];
            end
        end

        for (g = 0; g < `LDC_NUM_COM; g++)
        begin : g_com
            ldc_pkg::ldc_level_e lvl;
            ldc_line_drv u_drv
            (
                .active   (phase == `LDC_PHASE_W'(g)),
                .is_com   (1'h1),
                .positive (positive),
                .level    (lvl)
            );
            // lines held low while reset or idle
            assign com_level_d[2*g +: 2] = (lcd_rst || !run) ? 2'h0 : lvl;
        end

        for (g = 0; g < `LDC_NUM_SEG; g++)
        begin : g_seg
            ldc_pkg::ldc_level_e lvl;
            ldc_line_drv u_drv
            (
                .active   (mem_q[g][phase]),
                .is_com   (1'h0),
                .positive (positive),
                .level    (lvl)
            );
            assign seg_level_d[2*g +: 2] = (lcd_rst || !run) ? 2'h0 : lvl;
        end
    endgenerate

    assign drive_on_d = !lcd_rst && run;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            com_level_q <= '0;
            seg_level_q <= '0;
            drive_on_q  <= 1'h0;
        end
        else
        begin
            com_level_q <= com_level_d;
            seg_level_q <= seg_level_d;
            drive_on_q  <= drive_on_d;
        end
    end

    // helper: previous common phase for step checks
    logic [`LDC_PHASE_W-1:0] phase_prev_q;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            phase_prev_q <= '0;
        else
            phase_prev_q <= phase;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_sleep_low: assert property (
        sleep_mode |-> ##2 (com_level_q == '0 && seg_level_q == '0 && !drive_on_q))
        else $error("lines not low two cycles after sleep");

    chk_enable_off_low: assert property (
        !display_ctrl_first[`LDC_EN_BIT] |-> ##2 (com_level_q == '0 && seg_level_q == '0))
        else $error("lines not low two cycles after enable cleared");

    chk_reset_or: assert property (
        drive_on_q |-> ($past(display_on_ctl_q) && !$past(sleep_q)))
        else $error("display driven although disabled or asleep");

    chk_normal_drive: assert property (
        (display_on_ctl_q && !sleep_q) [*3] |-> drive_on_q)
        else $error("display not driving while enabled and awake");

    chk_power_on_off: assert property (
        $rose(reset_n) |-> !drive_on_q)
        else $error("display driving straight after power-on");

    chk_one_com_sel: assert property (
        drive_on_q |-> ($countones({com_level_q[7:6] == 2'h3 || com_level_q[7:6] == 2'h0,
                                    com_level_q[5:4] == 2'h3 || com_level_q[5:4] == 2'h0,
                                    com_level_q[3:2] == 2'h3 || com_level_q[3:2] == 2'h0,
                                    com_level_q[1:0] == 2'h3 || com_level_q[1:0] == 2'h0}) == 1))
        else $error("not exactly one common selected");

    chk_phase_step: assert property (
        (run && !lcd_rst && phase != phase_prev_q) |-> phase == phase_prev_q + 2'h1)
        else $error("common phase skipped");

    chk_phase_restart: assert property (
        lcd_rst |=> phase == '0)
        else $error("phase not restarted by lcd reset");

    chk_seg_memory: assert property (
        (drive_on_d && positive) |=>
            seg_level_q[1:0] == ($past(mem_q[0][phase]) ? 2'h0 : 2'h2))
        else $error("segment level does not follow memory");

    chk_type_a_flip: assert property (
        (run && !lcd_rst && wave_q == ldc_pkg::LDC_WAVE_A && !lcd_tick && $stable(wave_q))
            |=> positive == $past(positive))
        else $error("type a polarity moved without a tick");

    chk_type_b_frame: assert property (
        (run && !lcd_rst && wave_q == ldc_pkg::LDC_WAVE_B && $stable(wave_q)
            && phase != '0) |=> (phase == '0 || positive == $past(positive)))
        else $error("type b polarity changed inside a frame");

    chk_bias_follow: assert property (
        ##1 bias_kind_q == $past(display_ctrl_first[`LDC_BIAS_BIT]))
        else $error("bias kind not following control bit");

    chk_enable_follow: assert property (
        ##1 display_on_ctl_q == $past(display_ctrl_first[`LDC_EN_BIT]))
        else $error("enable not following control bit");

    chk_wave_follow: assert property (
        ##1 wave_q == $past(display_ctrl_first[`LDC_TYPE_BIT]))
        else $error("wave type not following control bit");

    chk_sleep_blank: assert property (
        sleep_q
            |=> (com_level_q == '0 && seg_level_q == '0 && !drive_on_q))
        else $error("lines not low while asleep");

    chk_off_blank: assert property (
        !display_on_ctl_q
            |=> (com_level_q == '0 && seg_level_q == '0 && !drive_on_q))
        else $error("lines not low while disabled");

    chk_idle_lines_low: assert property (
        !drive_on_q
            |-> (com_level_q == '0 && seg_level_q == '0))
        else $error("line driven while display off");

    chk_run_start: assert property (
        (!lcd_rst && !run)
            |=> run)
        else $error("sequencer did not start after lcd reset");

    chk_rst_stops_run: assert property (
        lcd_rst
            |=> !run)
        else $error("sequencer kept running in lcd reset");

    chk_phase_no_tick: assert property (
        (run && !lcd_rst && !lcd_tick)
            |=> $stable(phase))
        else $error("phase moved without a tick");

    chk_wake_first: assert property (
        $fell(lcd_rst)
            |-> (phase == '0 && positive))
        else $error("wake not at first phase and positive");

    chk_com_polarity: assert property (
        drive_on_d
            |=> com_level_q[2*phase_prev_q +: 2] == ($past(positive) ? 2'h3 : 2'h0))
        else $error("selected common at wrong level");

    chk_seg_negative: assert property (
        (drive_on_d && !positive)
            |=> seg_level_q[1:0] == ($past(mem_q[0][phase]) ? 2'h3 : 2'h1))
        else $error("negative segment level not mirrored");

    chk_type_a_start: assert property (
        (run && !lcd_rst && wave_q == ldc_pkg::LDC_WAVE_A && phase != phase_prev_q)
            |-> positive)
        else $error("type a division not starting positive");

    chk_type_b_wrap: assert property (
        (run && !lcd_rst && wave_q == ldc_pkg::LDC_WAVE_B && $stable(wave_q)
            && phase == 2'h0 && phase_prev_q == 2'h3) |-> positive != $past(positive))
        else $error("type b polarity not flipped at frame end");

    chk_mem_write: assert property (
        mem_wr_en
            |=> mem_q[$past(mem_wr_addr)] == $past(mem_wr_data))
        else $error("display memory write lost");

    chk_mem_hold: assert property (
        !(mem_wr_en && mem_wr_addr == 3'h0)
            |=> $stable(mem_q[0]))
        else $error("display memory row changed without write");

    cov_drive_a: cover property (drive_on_q && wave_q == ldc_pkg::LDC_WAVE_A && phase == 2'h3);
    cov_drive_b: cover property (drive_on_q && wave_q == ldc_pkg::LDC_WAVE_B && !positive);
    cov_sleep_in: cover property (drive_on_q ##1 sleep_mode ##2 !drive_on_q);
    cov_bias_c_on: cover property (drive_on_q && bias_kind_q);
    cov_wake_up: cover property ($fell(lcd_rst) ##3 drive_on_q);
endmodule // ldc_display_ctrl

/* File: ldc_panel_model.sv */
`timescale 1ns/1ns
// glass panel: sums com minus seg level of every pixel at each lcd tick
module ldc_panel_model
(
    input  wire logic         clk,
    input  wire logic         clear_acc,
    input  wire logic         lcd_tick,
    input  wire logic [7:0]   com_lv,
    input  wire logic [15:0]  seg_lv,
    output logic              dc_ok
);
    int acc [32];

    always @(posedge clk)
    begin
        for (int p = 0; p < 32; p++)
        begin
            if (clear_acc)
                acc[p] <= 0;
            else if (lcd_tick)
                acc[p] <= acc[p] + int'(com_lv[2*(p/8)+:2]) - int'(seg_lv[2*(p%8)+:2]);
        end
    end

    always_comb
    begin
        dc_ok = 1'b1;
        for (int p = 0; p < 32; p++)
            dc_ok = dc_ok && (acc[p] == 0);
    end
endmodule // ldc_panel_model

/* File: ldc_display_ctrl_tb.sv */
`timescale 1ns/1ns
`include "ldc_cfg.svh"
module ldc_display_ctrl_tb;
    logic        clk;
    logic        reset_n;
    logic [7:0]  ctrl;
    logic        sleep_mode;
    logic        lcd_tick;
    logic        mem_wr_en;
    logic [2:0]  mem_wr_addr;
    logic [3:0]  mem_wr_data;
    logic [7:0]  com_lv;
    logic [15:0] seg_lv;
    logic        bias_kind;
    logic        drive_on;
    logic        clear_acc;
    logic        dc_ok;
    logic [3:0]  mem_img [8];
    int          err_count;
    int          samples_checked;

    ldc_display_ctrl dut_u
    (
        .clk                (clk),
        .reset_n            (reset_n),
        .display_ctrl_first (ctrl),
        .sleep_mode         (sleep_mode),
        .lcd_tick           (lcd_tick),
        .mem_wr_en          (mem_wr_en),
        .mem_wr_addr        (mem_wr_addr),
        .mem_wr_data        (mem_wr_data),
        .com_level_q        (com_lv),
        .seg_level_q        (seg_lv),
        .bias_kind_q        (bias_kind),
        .drive_on_q         (drive_on)
    );

    ldc_panel_model panel_u
    (
        .clk       (clk),
        .clear_acc (clear_acc),
        .lcd_tick  (lcd_tick),
        .com_lv    (com_lv),
        .seg_lv    (seg_lv),
        .dc_ok     (dc_ok)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // expected {com, seg} levels for a phase and polarity
    function automatic logic [23:0] exp_lv(input int ph, input bit pos);
        logic [7:0]  c;
        logic [15:0] s;
        for (int i = 0; i < 4; i++)
            c[2*i+:2] = (i == ph) ? (pos ? 2'h3 : 2'h0) : (pos ? 2'h1 : 2'h2);
        for (int i = 0; i < 8; i++)
            s[2*i+:2] = mem_img[i][ph] ? (pos ? 2'h0 : 2'h3) : (pos ? 2'h2 : 2'h1);
        return {c, s};
    endfunction

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic tick();
        lcd_tick <= 1'b1;
        cycles(1);
        lcd_tick <= 1'b0;
        cycles(3);
    endtask

    task automatic load_memory();
        for (int r = 0; r < 8; r++)
        begin
            mem_img[r] = 4'(r * 5 + 3);
            mem_wr_en   <= 1'b1;
            mem_wr_addr <= 3'(r);
            mem_wr_data <= mem_img[r];
            cycles(1);
        end
        mem_wr_en <= 1'b0;
        cycles(1);
    endtask

    task automatic run_wave(input bit b);
        ctrl <= 8'h00;
        cycles(3);
        ctrl <= {b, 7'h01};
        cycles(4);
        clear_acc <= 1'b1;
        cycles(1);
        clear_acc <= 1'b0;
        check("drive on", 24'(drive_on), 24'h00_0001);
        for (int k = 0; k < 32; k++)
        begin
            check("levels", {com_lv, seg_lv}, exp_lv((k / 4) % 4, b ? (k < 16) : (k % 4 < 2)));
            tick();
        end
        check("dc balance", 24'(dc_ok), 24'h00_0001);
    endtask

    task automatic sleep_and_disable();
        tick();
        tick();
        sleep_mode <= 1'b1;
        cycles(3);
        check("sleep drive", 24'(drive_on), 24'h00_0000);
        check("sleep", {com_lv, seg_lv}, 24'h00_0000);
        sleep_mode <= 1'b0;
        cycles(4);
        check("wake", {com_lv, seg_lv}, exp_lv(0, 1));
        ctrl <= 8'h00;
        cycles(3);
        check("disable drive", 24'(drive_on), 24'h00_0000);
        check("disable", {com_lv, seg_lv}, 24'h00_0000);
    endtask

    task automatic bias_select();
        ctrl <= 8'h40;
        cycles(3);
        check("bias c", 24'(bias_kind), 24'h00_0001);
        ctrl <= 8'h41;
        cycles(3);
        check("bias c on", 24'(bias_kind), 24'h00_0001);
        ctrl <= 8'h01;
        cycles(3);
        check("bias r", 24'(bias_kind), 24'h00_0000);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        err_count = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        ctrl = 8'h00;
        sleep_mode = 1'b0;
        lcd_tick = 1'b0;
        mem_wr_en = 1'b0;
        mem_wr_addr = 3'h0;
        mem_wr_data = 4'h0;
        clear_acc = 1'b0;
        cycles(2);
        reset_n <= 1'b1;
        cycles(3);
        check("power on drive", 24'(drive_on), 24'h00_0000);
        check("power on", {com_lv, seg_lv}, 24'h00_0000);
        load_memory();
        run_wave(1'b0);
        run_wave(1'b1);
        ctrl <= 8'h00;
        cycles(3);
        ctrl <= 8'h01;
        cycles(4);
        sleep_and_disable();
        bias_select();
        ctrl <= 8'h00;
        reset_n <= 1'b0;
        cycles(2);
        reset_n <= 1'b1;
        cycles(3);
        check("second reset drive", 24'(drive_on), 24'h00_0000);
        check("second reset", {com_lv, seg_lv}, 24'h00_0000);
        tally_and_finish();
    end
endmodule // ldc_display_ctrl_tb
